// ==== see_array.sv ====
/*
 * storage array of the eeprom, one byte per word.
 * assumes a synchronous write and registered read.
 */
`default_nettype none
module see_array
   import see_pkg::*;
#(
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   // clock
   input wire logic sys_clk,
   // memory port
   see_mem_if.mem mp
);
   logic [7:0] cells [DEPTH];
   logic [7:0] rdata_r;
   always_ff @(posedge sys_clk) begin
      if (mp.we) begin
         cells[mp.addr] <= mp.wdata;
      end
      rdata_r <= cells[mp.addr];
   end
   assign mp.rdata = rdata_r;
endmodule // see_array
`default_nettype wire

// ==== see_bus_master.sv ====
/*
 * behavioural two-wire bus master on the serial pins.
 * assumes a pull-up merges its data output with the slave's.
 */
`default_nettype none
module see_bus_master (
   // serial pins
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaWire
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl = 1'b1; // clock stands high between frames
      sdaDrv = 1'b1;
   end
   // 125 ns per bit; data moves only while the clock is low
   task automatic bitx(input logic b, output logic r);
      #40 sdaDrv = b; // high only releases the line
      #23 scl = 1'b1;
      #31 r = sdaWire;
      #31 scl = 1'b0;
   endtask
   task automatic start();
      #40 sdaDrv = 1'b1;
      #23 scl = 1'b1;
      #31 sdaDrv = 1'b0; // fall with clock high
      #31 scl = 1'b0;
   endtask
   task automatic stop();
      #40 sdaDrv = 1'b0;
      #23 scl = 1'b1;
      #31 sdaDrv = 1'b1; // rise with clock high
      #31;
   endtask
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r); // msb first
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rdByte(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(~mack, r); // low continues, high ends the read
   endtask
endmodule // see_bus_master
`default_nettype wire

// ==== see_eeprom_slave.sv ====
/*
 * two-wire serial slave front end of a 128-byte data eeprom.
 * assumes an external master drives the clock pin and shares the
 * open-drain data pin; both pins are asynchronous to sys_clk.
 */
`include "see_regs.svh"
`default_nettype none
module see_eeprom_slave
   import see_pkg::*;
#(
   parameter int DEPTH = `SEE_DEPTH,
   parameter int PAGE_BYTES = `SEE_PAGE_BYTES,
   parameter int WRITE_CYC = `SEE_WRITE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial clock pin from the master
   input wire logic sclIn,
   // open-drain serial data pin
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe_n,
   // status
   output logic busy,
   output logic standby
);
   localparam int AW = `SEE_ADDR_W;
   localparam int PW = $clog2(PAGE_BYTES);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic scl, sclRise, sclFall, sda, sdaRise, sdaFall;
   // pins reach the logic two cycles late, so the serial clock must
   // stay well below a quarter of sys_clk for every phase to be seen
   see_sync u_scl (.sys_clk(sys_clk), .rst(rst), .pinIn(sclIn),
      .level(scl), .rise(sclRise), .fall(sclFall));
   see_sync u_sda (.sys_clk(sys_clk), .rst(rst), .pinIn(sdaIn),
      .level(sda), .rise(sdaRise), .fall(sdaFall));

   see_mem_if #(.AW(AW)) mif ();
   see_array #(.DEPTH(DEPTH), .AW(AW)) u_array (.sys_clk(sys_clk), .mp(mif.mem));

   // ----------------------------------------
   // bus condition decode
   // ----------------------------------------
   logic startCond, stopCond;
   // both pins pass the same synchroniser depth, so their order is kept
   assign startCond = sdaFall & scl;
   assign stopCond = sdaRise & scl;

   // ----------------------------------------
   // state
   // ----------------------------------------
   see_state_type state_r, state_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [AW-1:0] addr_r, addr_nxt;
   logic [7:0] wbyte_r, wbyte_nxt;
   logic wrPend_r, wrPend_nxt;
   logic ackSlot_r, ackSlot_nxt;
   logic drvLow_r, drvLow_nxt;
   logic [31:0] progCnt_r, progCnt_nxt;
   logic standby_r, standby_nxt;
   logic we;
   logic progDone;
   logic busy_r, busy_nxt;

   // ----------------------------------------
   // address counter steps
   // ----------------------------------------
   // reads roll over the whole array, writes stay inside their page
   function automatic logic [AW-1:0] rdInc(input logic [AW-1:0] a);
      rdInc = (32'(a) == DEPTH - 1) ? '0 : a + 1'b1;
   endfunction
   function automatic logic [AW-1:0] wrInc(input logic [AW-1:0] a);
      logic [PW-1:0] low;
      low = a[PW-1:0] + 1'b1;
      wrInc = {a[AW-1:PW], low};
   endfunction

   // ----------------------------------------
   // programming timer
   // ----------------------------------------
   // the byte lands in the array on the first cycle of the write cycle;
   // the rest only keeps the bus deaf for as long as the cells need
   always_comb begin
      progCnt_nxt = progCnt_r;
      we = 1'b0;
      progDone = 1'b0;
      if (state_r == ST_PROG) begin
         we = (progCnt_r == 32'h0);
         if (progCnt_r == 32'(WRITE_CYC - 1)) begin
            progCnt_nxt = 32'h0;
            progDone = 1'b1;
         end else begin
            progCnt_nxt = progCnt_r + 32'h1;
         end
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         progCnt_r <= 32'h0;
      end else begin
         progCnt_r <= progCnt_nxt;
      end
   end

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   // every pin event is seen one sys_clk cycle wide, so each branch
   // below acts once per serial clock edge
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      addr_nxt = addr_r;
      wbyte_nxt = wbyte_r;
      wrPend_nxt = wrPend_r;
      ackSlot_nxt = ackSlot_r;
      drvLow_nxt = drvLow_r;
      standby_nxt = standby_r;
      case (state_r)
         ST_PROG: begin
            // bus is ignored while programming, so polls see no ack
            drvLow_nxt = 1'b0;
            if (we) begin
               // counter moves past the written byte, inside its page
               addr_nxt = wrInc(addr_r);
               wrPend_nxt = 1'b0;
            end
            if (progDone) begin
               state_nxt = ST_IDLE;
               standby_nxt = 1'b1;
            end
         end
         default: begin
            if (startCond) begin
               // a start aborts anything but programming
               state_nxt = ST_DEV;
               bitCnt_nxt = '0;
               ackSlot_nxt = 1'b0;
               drvLow_nxt = 1'b0;
               wrPend_nxt = 1'b0;
               standby_nxt = 1'b0;
            end else if (stopCond) begin
               drvLow_nxt = 1'b0;
               if (wrPend_r) begin
                  // a complete write hands over to the write cycle
                  state_nxt = ST_PROG;
               end else begin
                  state_nxt = ST_IDLE;
                  standby_nxt = 1'b1;
               end
            end else if (state_r != ST_IDLE && sclRise) begin
               if (!ackSlot_r) begin
                  shift_nxt = {shift_r[6:0], sda};
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (state_r == ST_RACK) begin
                  if (!sda) begin
                     state_nxt = ST_RDATA;
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end
            end else if (state_r != ST_IDLE && sclFall) begin
               if (ackSlot_r) begin
                  // ninth clock done: release or reload shifter
                  ackSlot_nxt = 1'b0;
                  bitCnt_nxt = '0;
                  drvLow_nxt = 1'b0;
                  if (state_r == ST_RDATA) begin
                     shift_nxt = mif.rdata;
                     drvLow_nxt = ~mif.rdata[7];
                  end else if (state_r == ST_WDATA && wrPend_r) begin
                     state_nxt = ST_IDLE;
                  end
               end else if (state_r == ST_RDATA) begin
                  if (bitCnt_r == 4'h8) begin
                     // byte sent: the counter steps past it whatever the master answers
                     addr_nxt = rdInc(addr_r);
                     drvLow_nxt = 1'b0;
                     ackSlot_nxt = 1'b1;
                     state_nxt = ST_RACK;
                  end else begin
                     // the shifter already moved on the rising edge
                     drvLow_nxt = ~shift_r[7];
                  end
               end else if (bitCnt_r == 4'h8) begin
                  ackSlot_nxt = 1'b1;
                  case (state_r)
                     ST_DEV: begin
                        if (shift_r[7:4] == `SEE_PREFIX
                              && shift_r[3:1] == `SEE_SELECT) begin
                           drvLow_nxt = 1'b1;
                           state_nxt = shift_r[0] ? ST_RDATA : ST_WADDR;
                           if (shift_r[0]) begin
                              bitCnt_nxt = '0;
                           end
                        end else begin
                           state_nxt = ST_IDLE;
                           ackSlot_nxt = 1'b0;
                           standby_nxt = 1'b1;
                        end
                     end
                     ST_WADDR: begin
                        addr_nxt = shift_r[AW-1:0];
                        drvLow_nxt = 1'b1;
                        state_nxt = ST_WDATA;
                     end
                     ST_WDATA: begin
                        wbyte_nxt = shift_r;
                        wrPend_nxt = 1'b1;
                        drvLow_nxt = 1'b1;
                     end
                     default: begin
                        ackSlot_nxt = 1'b0;
                     end
                  endcase
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // protocol registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         bitCnt_r <= 4'h0;
         shift_r <= 8'hFF;
         addr_r <= '0;
         wbyte_r <= 8'h00;
         wrPend_r <= 1'b0;
         ackSlot_r <= 1'b0;
         drvLow_r <= 1'b0;
         standby_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         addr_r <= addr_nxt;
         wbyte_r <= wbyte_nxt;
         wrPend_r <= wrPend_nxt;
         ackSlot_r <= ackSlot_nxt;
         drvLow_r <= drvLow_nxt;
         standby_r <= standby_nxt;
      end
   end

   // ----------------------------------------
   // status outputs
   // ----------------------------------------
   // busy follows the next state so it rises with programming itself
   // and costs no extra cycle of latency
   always_comb begin
      busy_nxt = (state_nxt == ST_PROG);
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
      end
   end

   // ----------------------------------------
   // memory port and pins
   // ----------------------------------------
   assign mif.we = we;
   assign mif.addr = addr_r;
   assign mif.wdata = wbyte_r;
   // open drain: only ever a low, enable active low
   assign sdaOut = 1'b0;
   assign sdaOe_n = ~drvLow_r;
   assign busy = busy_r;
   assign standby = standby_r;
endmodule // see_eeprom_slave
`default_nettype wire

// ==== see_eeprom_slave_asserts.sv ====
/*
 * pin checker of the eeprom slave front end.
 * assumes it is bound to see_eeprom_slave and sees only its ports.
 */
`default_nettype none
module see_eeprom_slave_asserts #(
   parameter int WRITE_CYC = 625
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // serial pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe_n,
   // status
   input wire logic busy,
   input wire logic standby
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // -----------------------------------------------
   // helper counter of programming cycles
   // -----------------------------------------------
   int busyCnt_r;
   int busyCnt_nxt;
   always_comb busyCnt_nxt = busy ? busyCnt_r + 1 : 0;
   always_ff @(posedge sys_clk) busyCnt_r <= rst ? 0 : busyCnt_nxt;
   sequence s_pull_hold;
      !sdaOe_n [*8];
   endsequence
   // -----------------------------------------------
   // assertions
   // -----------------------------------------------
   chk_open_drain: assert property (sdaOut == 1'b0)
      else $error("data pin driven high");
   chk_reset_idle: assert property (disable iff (1'b0) rst |=> sdaOe_n && !busy && standby)
      else $error("outputs not idle after reset");
   chk_busy_quiet: assert property (busy |-> sdaOe_n)
      else $error("pin pulled while programming");
   chk_idle_quiet: assert property (standby |-> sdaOe_n)
      else $error("pin pulled in standby");
   chk_scl_low_chg: assert property ($changed(sdaOe_n) |-> !sclIn)
      else $error("data changed with clock high");
   chk_pull_after_fall: assert property ($fell(sdaOe_n) |-> !$past(sclIn, 2))
      else $error("pull not after clock fall");
   chk_pull_hold: assert property ($fell(sdaOe_n) |-> s_pull_hold)
      else $error("pull released too soon");
   chk_prog_stop: assert property ($rose(busy) |-> sclIn && sdaIn)
      else $error("programming began without stop");
   chk_prog_length: assert property (
      $fell(busy) |-> busyCnt_r inside {[WRITE_CYC-1:WRITE_CYC+4]})
      else $error("programming length wrong");
   chk_prog_standby: assert property ($fell(busy) |-> ##[0:2] standby)
      else $error("no standby after programming");
endmodule // see_eeprom_slave_asserts
bind see_eeprom_slave see_eeprom_slave_asserts #(.WRITE_CYC(WRITE_CYC))
   u_see_eeprom_slave_asserts (
   .sys_clk(sys_clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe_n(sdaOe_n), .busy(busy), .standby(standby));
`default_nettype wire

// ==== see_mem_if.sv ====
/*
 * memory port between the serial front end and the storage array.
 * assumes one clock shared by both ends.
 */
`default_nettype none
interface see_mem_if #(parameter int AW = 7);
   logic we;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== see_pkg.sv ====
/*
 * types shared by the eeprom slave modules.
 * assumes see_regs.svh holds the numeric constants.
 */
`default_nettype none
package see_pkg;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_DEV   = 7'h02,
      ST_WADDR = 7'h04,
      ST_WDATA = 7'h08,
      ST_RDATA = 7'h10,
      ST_RACK  = 7'h20,
      ST_PROG  = 7'h40
   } see_state_type;
endpackage
`default_nettype wire

// ==== see_regs.svh ====
/*
 * constants of the two-wire serial eeprom slave front end.
 * assumes inclusion by the design modules only.
 */
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH
`define SEE_DEPTH 128
`define SEE_ADDR_W 7
`define SEE_PREFIX 4'hA
`define SEE_SELECT 3'h0
`define SEE_PAGE_BYTES 8
`define SEE_WRITE_NS 5000
`define SEE_CLK_NS 8
`define SEE_WRITE_CYC ((`SEE_WRITE_NS + `SEE_CLK_NS - 1) / `SEE_CLK_NS)
`endif

// ==== see_sync.sv ====
/*
 * two-flop synchroniser with edge outputs for the serial pins.
 * assumes the inputs are asynchronous to sys_clk.
 */
`default_nettype none
module see_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pin
   input wire logic pinIn,
   // synchronised level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_r, sync_r, last_r;
   logic meta_nxt, sync_nxt, last_nxt;
   always_comb begin
      meta_nxt = pinIn;
      sync_nxt = meta_r;
      last_nxt = sync_r;
   end
   // idle bus level is high, so reset to one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_r <= 1'h1;
         sync_r <= 1'h1;
         last_r <= 1'h1;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         last_r <= last_nxt;
      end
   end
   assign level = sync_r;
   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule // see_sync
`default_nettype wire

// ==== tb_see_eeprom_slave.sv ====
/*
 * bench of the eeprom slave: writes, polling, reads, wrap.
 * assumes see_bus_master as the master on the pins.
 */
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_see_eeprom_slave;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WCYC = 400; // long enough that the first poll is refused
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic sclIn;
   logic sdaDrv;
   logic sdaOut;
   logic sdaOe_n;
   logic busy;
   logic standby;
   int fails = 0;
   int compares = 0;
   wire logic sdaWire = sdaDrv & (sdaOe_n | sdaOut); // pull-up
   always #4 sys_clk = ~sys_clk;
   see_eeprom_slave #(.WRITE_CYC(WCYC)) u_see_eeprom_slave (.sys_clk(sys_clk), .rst(rst),
      .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
      .busy(busy), .standby(standby));
   see_bus_master u_see_bus_master (.scl(sclIn), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
   // -----------------------------------------------
   // shared tasks
   // -----------------------------------------------
   // pin changes stay half a ns away from clock edges
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #0.5;
   endtask
   task automatic devCmd(input logic [7:0] dev, output logic k);
      u_see_bus_master.start();
      u_see_bus_master.wrByte(dev, k);
   endtask
   task automatic wrOne(input logic [7:0] a, input logic [7:0] d);
      logic k;
      int n;
      devCmd(8'hA0, k); `CHK(k, 1'b1)
      u_see_bus_master.wrByte(a, k); `CHK(k, 1'b1)
      u_see_bus_master.wrByte(d, k); `CHK(k, 1'b1)
      u_see_bus_master.stop();
      cyc(6); `CHK(busy, 1'b1)
      devCmd(8'hA0, k); `CHK(k, 1'b0)
      n = 0;
      while (!k && n < 10) begin
         devCmd(8'hA0, k);
         n++;
      end
      `CHK(k, 1'b1)
      u_see_bus_master.stop();
   endtask
   task automatic rdAt(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1,
         input logic two);
      logic k;
      logic [7:0] d;
      devCmd(8'hA0, k); `CHK(k, 1'b1)
      u_see_bus_master.wrByte(a, k); `CHK(k, 1'b1)
      devCmd(8'hA1, k); `CHK(k, 1'b1)
      u_see_bus_master.rdByte(two, d); `CHK(d, e0)
      if (two) begin
         u_see_bus_master.rdByte(1'b0, d);
         `CHK(d, e1)
      end
      u_see_bus_master.stop();
      cyc(6); `CHK(standby, 1'b1)
   endtask
   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task automatic t_write_poll();
      wrOne(8'h15, 8'hA5);
      $display("test write_poll done");
   endtask
   task automatic t_random();
      rdAt(8'h15, 8'hA5, 8'h00, 1'b0);
      $display("test random done");
   endtask
   task automatic t_badaddr();
      logic k;
      logic [7:0] bad[5] = '{8'hA2, 8'hAE, 8'hB0, 8'h20, 8'hA3};
      foreach (bad[i]) begin
         devCmd(bad[i], k); `CHK(k, 1'b0)
         u_see_bus_master.stop();
         cyc(4); `CHK(standby, 1'b1)
      end
      $display("test badaddr done");
   endtask
   task automatic t_wrap();
      logic k;
      logic [7:0] d;
      wrOne(8'h78, 8'h5A);
      wrOne(8'h7F, 8'h3C);
      wrOne(8'h00, 8'hC3);
      wrOne(8'h7F, 8'h3C);
      devCmd(8'hA1, k); `CHK(k, 1'b1)
      u_see_bus_master.rdByte(1'b0, d); `CHK(d, 8'h5A)
      u_see_bus_master.stop();
      rdAt(8'h7F, 8'h3C, 8'h00, 1'b0);
      devCmd(8'hA1, k); `CHK(k, 1'b1)
      u_see_bus_master.rdByte(1'b0, d); `CHK(d, 8'hC3)
      u_see_bus_master.stop();
      rdAt(8'h7F, 8'h3C, 8'hC3, 1'b1);
      $display("test wrap done");
   endtask
   task automatic finish_test();
      $display("counts compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      cyc(4);
      t_write_poll();
      t_random();
      t_badaddr();
      t_wrap();
      finish_test();
   end
   initial begin
      #400000;
      fails++;
      finish_test();
   end
endmodule // tb_see_eeprom_slave
`default_nettype wire
